// ==== hw/fps_host.sv ====
// Host sequencer: programming-mode entry and security set over the serial line
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`default_nettype none
module fps_host #(
  parameter int unsigned PIN_HOLD_CYC = fps_pkg::C_PIN_HOLD,
  parameter int unsigned R0_MIN_CYC = fps_pkg::C_R0_MIN,
  parameter int unsigned R0_MAX_CYC = fps_pkg::C_R0_MAX,
  parameter int unsigned L0_MIN_CYC = fps_pkg::C_L0_MIN,
  parameter int unsigned L0_MAX_CYC = fps_pkg::C_L0_MAX,
  parameter int unsigned LOW_NOM_CYC = fps_pkg::C_LOW_NOM,
  parameter int unsigned T2C_CYC = fps_pkg::C_2C,
  parameter int unsigned COM_CYC = fps_pkg::C_COM,
  parameter int unsigned RX_TMO_CYC = fps_pkg::C_RX_TMO
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Device pins
  output logic flash_mode_select_pin,
  output logic dev_reset_n,
  output logic txd,
  input wire logic rxd
);
  import fps_pkg::*;

  fps_state_t state_q;
  fps_err_t err_q;
  fps_sec_t sec_q;
  fps_cfg_t cfg_q;
  fps_stat_t stat;
  logic [31:0] cnt_q;
  logic [31:0] gap_q;
  logic [31:0] data_gap;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;
  logic go_entry_q;
  logic go_sec_q;
  logic go_end_q;
  logic session_q;
  logic done_q;
  logic first_cmd_q;
  logic force_low_q;
  logic rxd_s1_q;
  logic rxd_s2_q;
  logic tx_start_q;
  logic [7:0] tx_data_q;
  logic [3:0] tx_idx_q;
  logic [3:0] tx_len;
  logic [7:0] frame_byte;
  logic [7:0] cmd_sum;
  logic [7:0] data_sum;
  logic tx_busy;
  logic tx_line;
  logic rx_valid;
  logic [7:0] rx_data;
  logic [8:0] rx_idx_q;
  logic [7:0] rx_len_q;
  logic [7:0] rx_st_q;
  logic rx_frame_q;
  logic busy;

  // ====
  // Line input synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // ====
  // Byte engines
  fps_uart_tx u_tx (
    .clock(clock),
    .rst_n(rst_n),
    .baud_div(cfg_q.baud_div),
    .start(tx_start_q),
    .data(tx_data_q),
    .busy(tx_busy),
    .line(tx_line)
  );

  // Receiver never gated, so a status or data frame is never missed
  fps_uart_rx u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .baud_div(cfg_q.baud_div),
    .line(rxd_s2_q),
    .valid(rx_valid),
    .data(rx_data)
  );

  // ====
  // Frame contents
  assign cmd_sum = B_ZERO - (CMD_LEN + cfg_q.cmd_code);
  assign data_sum = B_ZERO - (DATA_LEN + sec_q.sec_flag + sec_q.boot_swap
                    + sec_q.fsws_low + sec_q.fswe_low);
  assign tx_len = (state_q == S_SEND_CMD) ? CMD_FRAME_BYTES : DATA_FRAME_BYTES;

  always_comb begin
    frame_byte = B_ZERO;
    if (state_q == S_SEND_CMD) begin
      case (tx_idx_q)
        4'h0: frame_byte = B_SOH;
        4'h1: frame_byte = CMD_LEN;
        4'h2: frame_byte = cfg_q.cmd_code;
        4'h3: frame_byte = B_ZERO;
        4'h4: frame_byte = B_ZERO;
        4'h5: frame_byte = cmd_sum;
        4'h6: frame_byte = B_ETX;
        default: frame_byte = B_ZERO;
      endcase
    end else begin
      case (tx_idx_q)
        4'h0: frame_byte = B_STX;
        4'h1: frame_byte = DATA_LEN;
        4'h2: frame_byte = sec_q.sec_flag;
        4'h3: frame_byte = sec_q.boot_swap;
        4'h4: frame_byte = B_ZERO;
        4'h5: frame_byte = sec_q.fsws_low;
        4'h6: frame_byte = B_ZERO;
        4'h7: frame_byte = sec_q.fswe_low;
        4'h8: frame_byte = data_sum;
        4'h9: frame_byte = B_ETX;
        default: frame_byte = B_ZERO;
      endcase
    end
  end

  // Gap from status frame to data frame, never below the frame-to-frame gap
  always_comb begin
    case (cfg_q.gap_sel)
      GAP_PROG: data_gap = C_FD2;
      GAP_VERIFY: data_gap = C_FD3;
      default: data_gap = C_FD4;
    endcase
    if (data_gap < C_DR) begin
      data_gap = C_DR;
    end
  end

  // ====
  // Status frame parser: STX, length, payload, checksum, ETX
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_idx_q <= 9'h000;
      rx_len_q <= 8'h00;
      rx_st_q <= 8'h00;
      rx_frame_q <= 1'b0;
    end else begin
      rx_frame_q <= 1'b0;
      if (rx_valid) begin
        if (rx_idx_q == 9'h000) begin
          if (rx_data == B_STX) begin
            rx_idx_q <= 9'h001;
          end
        end else begin
          rx_idx_q <= rx_idx_q + 9'h001;
          if (rx_idx_q == 9'h001) begin
            rx_len_q <= rx_data;
          end
          if (rx_idx_q == 9'h002) begin
            rx_st_q <= rx_data;
          end
          if (rx_idx_q > 9'h001 && rx_idx_q == {1'b0, rx_len_q} + 9'h003) begin
            rx_idx_q <= 9'h000;
            rx_frame_q <= 1'b1;
          end
        end
      end
    end
  end

  // Cycles since the last complete frame from the device, saturating
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_q <= 32'h0000_0000;
    end else if (rx_frame_q) begin
      gap_q <= 32'h0000_0000;
    end else if (gap_q != 32'hFFFF_FFFF) begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end

  // ====
  // Sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      err_q <= E_NONE;
      cnt_q <= 32'h0000_0000;
      session_q <= 1'b0;
      done_q <= 1'b0;
      first_cmd_q <= 1'b0;
      force_low_q <= 1'b0;
      flash_mode_select_pin <= 1'b0;
      dev_reset_n <= 1'b0;
      txd <= 1'b1;
      tx_start_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_idx_q <= 4'h0;
    end else begin
      txd <= tx_line & !force_low_q;
      tx_start_q <= 1'b0;
      cnt_q <= cnt_q + 32'h0000_0001;
      if (go_end_q) begin
        state_q <= S_IDLE;
        session_q <= 1'b0;
        force_low_q <= 1'b0;
        flash_mode_select_pin <= 1'b0;
        dev_reset_n <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            cnt_q <= 32'h0000_0000;
            if (go_entry_q) begin
              flash_mode_select_pin <= 1'b1;
              dev_reset_n <= 1'b0;
              err_q <= E_NONE;
              done_q <= 1'b0;
              state_q <= S_PIN_HOLD;
            end
          end
          S_PIN_HOLD: begin
            if (cnt_q >= PIN_HOLD_CYC - 1) begin
              dev_reset_n <= 1'b1;
              cnt_q <= 32'h0000_0000;
              state_q <= S_WAIT_READY;
            end
          end
          S_WAIT_READY: begin
            if (!rxd_s2_q) begin
              cnt_q <= 32'h0000_0000;
              state_q <= S_READY_LOW;
              if (cnt_q < R0_MIN_CYC) begin
                err_q <= E_READY_EARLY;
                flash_mode_select_pin <= 1'b0;
                dev_reset_n <= 1'b0;
                state_q <= S_IDLE;
              end
            end else if (cnt_q >= R0_MAX_CYC) begin
              err_q <= E_READY_LATE;
              flash_mode_select_pin <= 1'b0;
              dev_reset_n <= 1'b0;
              state_q <= S_IDLE;
            end
          end
          S_READY_LOW: begin
            if (rxd_s2_q && cnt_q >= L0_MIN_CYC) begin
              cnt_q <= 32'h0000_0000;
              state_q <= S_GAP1;
            end else if (rxd_s2_q || cnt_q > L0_MAX_CYC) begin
              err_q <= E_READY_WIDTH;
              flash_mode_select_pin <= 1'b0;
              dev_reset_n <= 1'b0;
              state_q <= S_IDLE;
            end
          end
          S_GAP1: begin
            if (cnt_q >= C_01 - 32'h0000_0001) begin
              force_low_q <= 1'b1;
              cnt_q <= 32'h0000_0000;
              state_q <= S_PULSE1;
            end
          end
          S_PULSE1, S_PULSE2: begin
            if (cnt_q >= LOW_NOM_CYC - 1) begin
              force_low_q <= 1'b0;
              cnt_q <= 32'h0000_0000;
              state_q <= (state_q == S_PULSE1) ? S_GAP2 : S_GAP3;
            end
          end
          S_GAP2: begin
            if (cnt_q >= C_02 - 32'h0000_0001) begin
              force_low_q <= 1'b1;
              cnt_q <= 32'h0000_0000;
              state_q <= S_PULSE2;
            end
          end
          S_GAP3: begin
            if (cnt_q >= T2C_CYC - 1) begin
              session_q <= 1'b1;
              first_cmd_q <= 1'b1;
              state_q <= S_LINKED;
            end
          end
          S_LINKED: begin
            if (go_sec_q) begin
              err_q <= E_NONE;
              done_q <= 1'b0;
              state_q <= S_CMD_WAIT;
            end
          end
          S_CMD_WAIT: begin
            if (first_cmd_q || gap_q >= COM_CYC) begin
              first_cmd_q <= 1'b0;
              tx_idx_q <= 4'h0;
              state_q <= S_SEND_CMD;
            end
          end
          S_DATA_WAIT: begin
            if (gap_q >= data_gap) begin
              tx_idx_q <= 4'h0;
              state_q <= S_SEND_DATA;
            end
          end
          S_SEND_CMD, S_SEND_DATA: begin
            cnt_q <= 32'h0000_0000;
            if (!tx_busy && !tx_start_q) begin
              if (tx_idx_q == tx_len) begin
                state_q <= (state_q == S_SEND_CMD) ? S_WAIT_ST1 : S_WAIT_ST2;
              end else begin
                tx_data_q <= frame_byte;
                tx_start_q <= 1'b1;
                tx_idx_q <= tx_idx_q + 4'h1;
              end
            end
          end
          S_WAIT_ST1, S_WAIT_ST2, S_WAIT_ST3: begin
            if (rx_frame_q) begin
              cnt_q <= 32'h0000_0000;
              state_q <= S_LINKED;
              if (rx_st_q == B_ACK) begin
                if (state_q == S_WAIT_ST1) begin
                  state_q <= S_DATA_WAIT;
                end else if (state_q == S_WAIT_ST2) begin
                  state_q <= S_WAIT_ST3;
                end else begin
                  done_q <= 1'b1;
                end
              end else if (state_q == S_WAIT_ST1) begin
                err_q <= E_CMD_NACK;
              end else if (rx_st_q == B_WR_FAIL_A || rx_st_q == B_WR_FAIL_B
                           || rx_st_q == B_WR_FAIL_C) begin
                err_q <= E_WRITE_FAIL;
              end else begin
                err_q <= (state_q == S_WAIT_ST2) ? E_DATA_NACK : E_WRITE_NACK;
              end
            end else if (cnt_q >= RX_TMO_CYC - 1) begin
              err_q <= E_RX_TIMEOUT;
              state_q <= S_LINKED;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ====
  // Register slave, one wait cycle per access
  assign busy = (state_q != S_IDLE) && (state_q != S_LINKED);
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb begin
    stat = '0;
    stat.last_status = rx_st_q;
    stat.err = err_q;
    stat.done = done_q;
    stat.busy = busy;
    stat.session = session_q;
    stat.state = state_q;
    case (avs_address[3:2])
      REG_SEC: rd_mux = sec_q;
      REG_CFG: rd_mux = cfg_q;
      REG_STAT: rd_mux = stat;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      sec_q <= SEC_RESET;
      cfg_q <= CFG_RESET;
      go_entry_q <= 1'b0;
      go_sec_q <= 1'b0;
      go_end_q <= 1'b0;
    end else begin
      go_entry_q <= 1'b0;
      go_sec_q <= 1'b0;
      go_end_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      // Waitrequest rises again after each answer, so a request held past its answer is taken again two cycles after the first
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
        if (avs_write) begin
          case (avs_address[3:2])
            REG_CTRL: begin
              go_entry_q <= avs_byteenable[0] && avs_writedata[CTRL_ENTRY_BIT];
              go_sec_q <= avs_byteenable[0] && avs_writedata[CTRL_SEC_BIT];
              go_end_q <= avs_byteenable[0] && avs_writedata[CTRL_END_BIT];
            end
            REG_SEC: sec_q <= fps_sec_t'((sec_q & ~be_mask) | (avs_writedata & be_mask));
            REG_CFG: cfg_q <= fps_cfg_t'((cfg_q & ~be_mask) | (avs_writedata & be_mask));
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule // fps_host
`default_nettype wire

// ==== hw/fps_pkg.sv ====
// Shared constants, types and timing counts of the flash programming sequencer
`default_nettype none
// Behaviour
// - Host waits at least 120 us after ready before first low byte
// - Host waits at least 10 us between first and second low byte
// - Host waits at least 300 us after second low byte before first command
// - Every entry low pulse equals one 00H byte at 9600 bps, nine bits
// - Host leaves at least 8.0 us between consecutive data frames
// - Program command: at least 8.7 us from status to data frame
// - Verify command: at least 145 us from status to data frame
// - Security set: at least 120 us from status to data frame
// - Host waits at least 595 us after status before a new command
// - Host receiver stays enabled, timeout at least 3 seconds
// - Security data frame carries six bytes in the fixed order
package fps_pkg;
  // ====
  // Clock and timing
  localparam longint unsigned CLK_HZ = 64'd20000000;
  localparam longint unsigned NS_PER_S = 64'd1000000000;
  function automatic longint unsigned cyc_up(input longint unsigned ns);
    return (ns * CLK_HZ + NS_PER_S - 64'd1) / NS_PER_S;
  endfunction
  function automatic longint unsigned cyc_dn(input longint unsigned ns);
    return (ns * CLK_HZ) / NS_PER_S;
  endfunction
  localparam longint unsigned T_PIN_HOLD_NS = 64'd2000000;
  localparam longint unsigned T_R0_MIN_NS = 64'd3000000;
  localparam longint unsigned T_R0_MAX_NS = 64'd100000000;
  localparam longint unsigned T_L0_MIN_NS = 64'd892000;
  localparam longint unsigned T_L0_MAX_NS = 64'd987000;
  localparam longint unsigned T_LOW_NOM_NS = 64'd937500;
  localparam longint unsigned T_01_NS = 64'd120000;
  localparam longint unsigned T_02_NS = 64'd10000;
  localparam longint unsigned T_2C_NS = 64'd300000;
  localparam longint unsigned T_DR_NS = 64'd8000;
  localparam longint unsigned T_FD2_NS = 64'd8700;
  localparam longint unsigned T_FD3_NS = 64'd145000;
  localparam longint unsigned T_FD4_NS = 64'd120000;
  localparam longint unsigned T_COM_NS = 64'd595000;
  localparam longint unsigned T_RX_TMO_NS = 64'd3000000000;
  localparam int unsigned C_PIN_HOLD = 32'(cyc_up(T_PIN_HOLD_NS));
  localparam int unsigned C_R0_MIN = 32'(cyc_up(T_R0_MIN_NS));
  localparam int unsigned C_R0_MAX = 32'(cyc_dn(T_R0_MAX_NS));
  localparam int unsigned C_L0_MIN = 32'(cyc_up(T_L0_MIN_NS));
  localparam int unsigned C_L0_MAX = 32'(cyc_dn(T_L0_MAX_NS));
  localparam int unsigned C_LOW_NOM = 32'(cyc_up(T_LOW_NOM_NS));
  localparam logic [31:0] C_01 = 32'(cyc_up(T_01_NS));
  localparam logic [31:0] C_02 = 32'(cyc_up(T_02_NS));
  localparam int unsigned C_2C = 32'(cyc_up(T_2C_NS));
  localparam logic [31:0] C_DR = 32'(cyc_up(T_DR_NS));
  localparam logic [31:0] C_FD2 = 32'(cyc_up(T_FD2_NS));
  localparam logic [31:0] C_FD3 = 32'(cyc_up(T_FD3_NS));
  localparam logic [31:0] C_FD4 = 32'(cyc_up(T_FD4_NS));
  localparam int unsigned C_COM = 32'(cyc_up(T_COM_NS));
  localparam int unsigned C_RX_TMO = 32'(cyc_up(T_RX_TMO_NS));
  localparam logic [15:0] BAUD_DIV_9600 = 16'(CLK_HZ / 64'd9600);
  // ====
  // Frame bytes
  localparam logic [7:0] B_SOH = 8'h01;
  localparam logic [7:0] B_STX = 8'h02;
  localparam logic [7:0] B_ETX = 8'h03;
  localparam logic [7:0] B_ACK = 8'h06;
  localparam logic [7:0] B_WR_FAIL_A = 8'h1A;
  localparam logic [7:0] B_WR_FAIL_B = 8'h1B;
  localparam logic [7:0] B_WR_FAIL_C = 8'h1C;
  localparam logic [7:0] B_ZERO = 8'h00;
  localparam logic [7:0] CMD_LEN = 8'h03;
  localparam logic [7:0] DATA_LEN = 8'h06;
  localparam logic [3:0] CMD_FRAME_BYTES = 4'h7;
  localparam logic [3:0] DATA_FRAME_BYTES = 4'hA;
  // Arbitrary default, software sets the real code
  localparam logic [7:0] CMD_SEC_CODE = 8'hA0;
  localparam logic [1:0] GAP_SEC = 2'h0;
  localparam logic [1:0] GAP_PROG = 2'h1;
  localparam logic [1:0] GAP_VERIFY = 2'h2;
  // ====
  // Register map
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_SEC = 2'h1;
  localparam logic [1:0] REG_CFG = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam int CTRL_ENTRY_BIT = 0;
  localparam int CTRL_SEC_BIT = 1;
  localparam int CTRL_END_BIT = 2;
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_PIN_HOLD = 5'h01, S_WAIT_READY = 5'h02, S_READY_LOW = 5'h03,
    S_GAP1 = 5'h04, S_PULSE1 = 5'h05, S_GAP2 = 5'h06, S_PULSE2 = 5'h07,
    S_GAP3 = 5'h08, S_LINKED = 5'h09, S_CMD_WAIT = 5'h0A, S_SEND_CMD = 5'h0B,
    S_WAIT_ST1 = 5'h0C, S_DATA_WAIT = 5'h0D, S_SEND_DATA = 5'h0E, S_WAIT_ST2 = 5'h0F,
    S_WAIT_ST3 = 5'h10
  } fps_state_t;
  typedef enum logic [3:0] {
    E_NONE = 4'h0, E_READY_EARLY = 4'h1, E_READY_LATE = 4'h2, E_READY_WIDTH = 4'h3,
    E_RX_TIMEOUT = 4'h4, E_CMD_NACK = 4'h5, E_DATA_NACK = 4'h6, E_WRITE_FAIL = 4'h7,
    E_WRITE_NACK = 4'h8
  } fps_err_t;
  typedef struct packed {
    logic [7:0] fswe_low;
    logic [7:0] fsws_low;
    logic [7:0] boot_swap;
    logic [7:0] sec_flag;
  } fps_sec_t;
  typedef struct packed {
    logic [7:0] cmd_code;
    logic [5:0] rsvd;
    logic [1:0] gap_sel;
    logic [15:0] baud_div;
  } fps_cfg_t;
  typedef struct packed {
    logic [7:0] rsvd1;
    logic [7:0] last_status;
    logic [3:0] rsvd0;
    fps_err_t err;
    logic done;
    logic busy;
    logic session;
    fps_state_t state;
  } fps_stat_t;
  localparam fps_sec_t SEC_RESET = 32'h0000_0000;
  localparam fps_cfg_t CFG_RESET = {CMD_SEC_CODE, 6'h00, GAP_SEC, BAUD_DIV_9600};
endpackage
`default_nettype wire

// ==== hw/fps_uart_rx.sv ====
// Byte receiver for the serial programming line, samples at mid bit
`default_nettype none
module fps_uart_rx (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Line, already synchronised
  input wire logic [15:0] baud_div,
  input wire logic line,
  // Received byte
  output logic valid,
  output logic [7:0] data
);
  logic active_q;
  logic [15:0] baud_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  // ====
  // Sampler
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      baud_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      valid <= 1'b0;
      data <= 8'h00;
    end else begin
      valid <= 1'b0;
      if (!active_q) begin
        if (!line) begin
          active_q <= 1'b1;
          baud_q <= {1'b0, baud_div[15:1]};
          bit_q <= 4'h0;
        end
      end else if (baud_q != 16'h0000) begin
        baud_q <= baud_q - 16'h0001;
      end else begin
        baud_q <= baud_div - 16'h0001;
        if (bit_q == 4'h0) begin
          // A glitch shorter than half a bit is no start bit
          active_q <= !line;
          bit_q <= 4'h1;
        end else if (bit_q <= 4'h8) begin
          shift_q <= {line, shift_q[7:1]};
          bit_q <= bit_q + 4'h1;
        end else begin
          active_q <= 1'b0;
          valid <= line;
          data <= shift_q;
        end
      end
    end
  end
endmodule // fps_uart_rx
`default_nettype wire

// ==== hw/fps_uart_tx.sv ====
// Byte transmitter for the serial programming line, 8N1, idle high
`default_nettype none
module fps_uart_tx (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Byte request
  input wire logic [15:0] baud_div,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  // Line
  output logic line
);
  logic [15:0] baud_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  // ====
  // Shifter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      baud_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 9'h1FF;
      busy <= 1'b0;
      line <= 1'b1;
    end else if (!busy) begin
      if (start) begin
        line <= 1'b0;
        shift_q <= {1'b1, data};
        bit_q <= 4'h9;
        baud_q <= baud_div - 16'h0001;
        busy <= 1'b1;
      end
    end else if (baud_q != 16'h0000) begin
      baud_q <= baud_q - 16'h0001;
    end else if (bit_q == 4'h0) begin
      busy <= 1'b0;
    end else begin
      line <= shift_q[0];
      shift_q <= {1'b1, shift_q[8:1]};
      bit_q <= bit_q - 4'h1;
      baud_q <= baud_div - 16'h0001;
    end
  end
endmodule // fps_uart_tx
`default_nettype wire

// ==== verif/fps_dev_model.sv ====
// Behavioural target device on the serial programming line
`default_nettype none
module fps_dev_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic clock,
  // Device pins
  input wire logic dev_reset_n,
  input wire logic txd,
  output logic rxd,
  // Write result chosen by the bench
  input wire logic [7:0] final_status
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Serial byte tasks
  logic [0:16][7:0] rx_buf;
  task automatic send(input logic [9:0] b);
    for (int i = 0; i < 10; i++) begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge clock);
    end
  endtask
  // Frames go back to back with no pause, the harshest timing for the receiver
  task automatic status(input logic [7:0] s);
    logic [39:0] f;
    f = {8'h02, 8'h01, s, 8'h00 - 8'h01 - s, 8'h03};
    for (int i = 4; i >= 0; i--) send({1'b1, f[8*i +: 8], 1'b0});
  endtask
  task automatic get(input int n, input int at);
    for (int k = at; k < at + n; k++) begin
      while (txd) @(posedge clock);
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        rx_buf[k][i] = txd;
        repeat (BIT_CYC) @(posedge clock);
      end
    end
  endtask
  // ====
  // Session
  initial begin
    rxd = 1'b1;
    @(posedge dev_reset_n);
    repeat (100) @(posedge clock);
    rxd <= 1'b0;
    repeat (150) @(posedge clock);
    rxd <= 1'b1;
    repeat (2) @(posedge txd);
    forever begin
      get(7, 0);
      status(8'h06);
      get(10, 7);
      status(8'h06);
      status(final_status);
    end
  end
endmodule // fps_dev_model
`default_nettype wire

// ==== verif/fps_host_monitor.sv ====
// Port checker for the host sequencer
`default_nettype none
module fps_host_monitor #(
  parameter int PIN_HOLD_CYC = 40,
  parameter int LOW_NOM_CYC = 150,
  parameter int COM_CYC = 100,
  parameter int BAUD_CYC = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Device pins
  input wire logic flash_mode_select_pin,
  input wire logic dev_reset_n,
  input wire logic txd,
  input wire logic rxd
);
  // ====
  // Helper counters, quiet_q saturates so long idle spans do not wrap it; hold_q and low_q wrap
  logic [15:0] hold_q, low_q, quiet_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_q <= 16'h0000;
      low_q <= 16'h0000;
      quiet_q <= 16'hFFFF;
    end else begin
      hold_q <= (flash_mode_select_pin && !dev_reset_n) ? hold_q + 16'h0001 : 16'h0000;
      low_q <= txd ? 16'h0000 : low_q + 16'h0001;
      quiet_q <= $rose(rxd) ? 16'h0000 : quiet_q + {15'h0000, quiet_q != 16'hFFFF};
    end
  end
  // ====
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ctrl_read_s;
    taken_s ##0 (avs_read && avs_address[3:2] == 2'h0);
  endsequence
  AST_WAIT_ONE: assert property (taken_s |=> !avs_waitrequest)
    else $error("wait state count wrong");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_CTRL_ZERO: assert property (ctrl_read_s |=> avs_readdata == 32'h0000_0000)
    else $error("control read not zero");
  AST_PIN_HOLD: assert property ($rose(dev_reset_n) |-> hold_q >= 16'(PIN_HOLD_CYC))
    else $error("reset released too early");
  AST_RESET_HELD: assert property (!flash_mode_select_pin |-> !dev_reset_n)
    else $error("reset high without mode pin");
  AST_ENTRY_PULSE: assert property ($rose(txd) && low_q > 16'(9 * BAUD_CYC) |->
    low_q == 16'(LOW_NOM_CYC))
    else $error("entry pulse width wrong");
  AST_TX_QUIET: assert property ($fell(txd) |-> quiet_q >= 16'(COM_CYC))
    else $error("sent too soon after device");
  AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n |=>
    txd && !flash_mode_select_pin && !dev_reset_n && avs_waitrequest)
    else $error("outputs not idle in reset");
endmodule // fps_host_monitor
bind fps_host fps_host_monitor #(.PIN_HOLD_CYC(PIN_HOLD_CYC), .LOW_NOM_CYC(LOW_NOM_CYC),
  .COM_CYC(COM_CYC)) fps_host_monitor_inst (.clock, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .flash_mode_select_pin, .dev_reset_n, .txd, .rxd);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the host sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fps_pkg::*;
  // ====
  // Harness
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic flash_mode_select_pin, dev_reset_n, txd, rxd;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] final_status;
  int bad_count, check_count;
  fps_host #(.PIN_HOLD_CYC(40), .R0_MIN_CYC(60), .L0_MIN_CYC(100), .LOW_NOM_CYC(150),
    .COM_CYC(100))
    fps_host_inst (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .flash_mode_select_pin, .dev_reset_n,
    .txd, .rxd);
  fps_dev_model fps_dev_model_inst (.clock, .dev_reset_n, .txd, .rxd, .final_status);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_linked;
    repeat (20) @(posedge clock);
    do bus(1'b0, 4'hC, 32'h0); while (rd[4:0] !== 5'h09);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_regs;
    bus(1'b0, 4'h8, 32'h0);
    check("cfg reset", CFG_RESET, rd);
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl", 32'h0, rd);
    bus(1'b0, 4'hC, 32'h0);
    check("stat reset", 32'h0, rd);
    bus(1'b1, 4'h8, 32'hA000_0010);
    bus(1'b1, 4'h4, 32'h3322_1155);
    bus(1'b0, 4'h4, 32'h0);
    check("sec", 32'h3322_1155, rd);
  endtask
  task automatic t_sec;
    logic [7:0] code [5] = '{8'h06, 8'h1A, 8'h1B, 8'h1C, 8'h05};
    logic [3:0] err [5] = '{4'h0, 4'h7, 4'h7, 4'h7, 4'h8};
    logic [0:16][7:0] f;
    for (int i = 0; i < 5; i++) begin
      final_status <= code[i];
      bus(1'b1, 4'h0, 32'h2);
      wait_linked;
      check("error", {28'h0, err[i]}, {28'h0, rd[11:8]});
      check("done", {31'h0, i == 0}, {31'h0, rd[7]});
      check("last", {24'h0, code[i]}, {24'h0, rd[23:16]});
    end
    f = fps_dev_model_inst.rx_buf;
    check("cmd", 32'h03A0_0000, f[1:4]);
    check("data a", 32'h5511_0022, f[9:12]);
    check("data b", 32'h0033_0206, {f[13:14], f[7:8]});
  endtask
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    final_status = 8'h06;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    bus(1'b1, 4'h0, 32'h1);
    wait_linked;
    check("session", 32'h1, {31'h0, rd[5]});
    t_sec;
    bus(1'b1, 4'h0, 32'h4);
    bus(1'b0, 4'hC, 32'h0);
    check("ended", 32'h0, {27'h0, rd[4:0]});
    end_sim;
  end
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
